// [logic/tap_pkg.sv]
/*
 * Constants for the memory boundary-scan test port: controller states,
 * instruction codes, register lengths and reset values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tap_pkg;

    // ------------------------------------------------------------
    // Register lengths and reset edge count
    // ------------------------------------------------------------
    localparam int IR_LEN   = 3;
    localparam int ID_LEN   = 32;
    localparam int BSR_LEN  = 109;
    localparam int TLR_HOLD = 5;    // Rising edges with mode select high

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [2:0] INS_EXTERNAL = 3'h0;
    localparam logic [2:0] INS_IDENT    = 3'h1;
    localparam logic [2:0] INS_FLOAT    = 3'h2;
    localparam logic [2:0] INS_SAMPLE   = 3'h4;
    localparam logic [2:0] INS_BYPASS   = 3'h7;
    localparam logic [2:0] IR_RESET     = INS_IDENT;
    localparam logic [2:0] IR_CAPTURE   = 3'h1;   // Fixed pattern, low bits 01

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET      = 4'h0,
        ST_IDLE       = 4'h1,
        ST_SEL_DR     = 4'h2,
        ST_CAP_DR     = 4'h3,
        ST_SHIFT_DR   = 4'h4,
        ST_EXIT1_DR   = 4'h5,
        ST_PAUSE_DR   = 4'h6,
        ST_EXIT2_DR   = 4'h7,
        ST_UPD_DR     = 4'h8,
        ST_SEL_IR     = 4'h9,
        ST_CAP_IR     = 4'hA,
        ST_SHIFT_IR   = 4'hB,
        ST_EXIT1_IR   = 4'hC,
        ST_PAUSE_IR   = 4'hD,
        ST_EXIT2_IR   = 4'hE,
        ST_UPD_IR     = 4'hF
    } tap_state_e;

endpackage

// [logic/tap_fsm.sv]
/*
 * Sixteen-state test port controller, stepped once per step pulse while ce is high.
 * Assumes step is a one-cycle pulse on the sampled test clock rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tap_fsm
    import tap_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    // Step and mode select
    input  wire logic       step,
    input  wire logic       tms,
    // State
    output var  tap_state_e state
);

    tap_state_e next_state;

    // ------------------------------------------------------------
    // Next state from mode select
    // ------------------------------------------------------------
    always_comb begin
        case (state)
            ST_RESET:    next_state = tms ? ST_RESET    : ST_IDLE;
            ST_IDLE:     next_state = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   next_state = tms ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   next_state = tms ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
            default:     next_state = ST_RESET;
        endcase
    end

    // State register, power-up reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_RESET;
        end else if (ce && step) begin
            state <= next_state;
        end
    end

endmodule
`default_nettype wire

// [logic/sram_tap.sv]
/*
 * Boundary-scan test port of a burst static memory: pin sampling, the
 * controller, instruction, bypass, identity and boundary registers.
 * Assumes the test clock is sampled by SYS_CLK, at least 8x faster, and the
 * memory core supplies its pin states and consumes the driven values.
 */
// Functional notes
// - Only a reduced instruction subset is implemented, not the full standard.
// - Mode select and data in are sampled on the test clock rising edge.
// - Sampled mode select alone steers the controller between states.
// - Data in feeds the register chosen by state and loaded instruction.
// - Data out comes from the chosen register, changing on falling edges.
// - Five rising edges with mode select high reach reset; no reset pin.
// - Controller resets at power-up without any test clock.
// - Data in and mode select are weakly pulled high inside; code only resets their synchronisers high.
// - Identity instruction 001 is default after reset and captures 32 bits.
// - Instruction 010 floats memory outputs and samples inputs into the chain.
// - Instruction 000 drives preloaded output cells from instruction update.
`timescale 1ns/1ps
`default_nettype none
module sram_tap
    import tap_pkg::*;
#(
    parameter int         BS_LEN  = BSR_LEN,
    parameter logic [31:0] ID_CODE = 32'h1234_5671   // Arbitrary value
)
(
    // Clock, reset, enable
    input  wire logic              SYS_CLK,
    input  wire logic              NRST,
    input  wire logic              CE,
    // Test port pins
    input  wire logic              TCK,
    input  wire logic              TMS,
    input  wire logic              TDI,
    output logic                   TDO,
    output logic                   TDO_OE_N,
    // Boundary cells toward the memory core
    input  wire logic [BS_LEN-1:0] PIN_STATE,
    output logic [BS_LEN-1:0]      PIN_DRIVE,
    output logic                   DRIVE_EN,
    output logic                   FLOAT_OUT,
    // Observation
    output logic [3:0]             TAP_STATE
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0]        tck_sync;
    logic [1:0]        tms_sync;
    logic [1:0]        tdi_sync;
    logic [BS_LEN-1:0] pin_meta;
    logic [BS_LEN-1:0] pin_sync;
    logic              tck_prev;
    logic              rise;
    logic              fall;
    tap_state_e        state;
    logic [2:0]        ir_shift;
    logic [2:0]        ir;
    logic              bypass;
    logic [31:0]       id_shift;
    logic [BS_LEN-1:0] bs_shift;
    logic [BS_LEN-1:0] bs_update;
    logic              next_tdo;
    logic              shifting;

    // Instruction decode used in several places
    function automatic logic sel_boundary(input logic [2:0] code);
        return (code == INS_EXTERNAL) || (code == INS_FLOAT) || (code == INS_SAMPLE);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers; mode select and data in reset high, no pull-up
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            tck_sync <= 2'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h3;
            tck_prev <= 1'b0;
        end else if (CE) begin
            tck_sync <= {tck_sync[0], TCK};
            tms_sync <= {tms_sync[0], TMS};
            tdi_sync <= {tdi_sync[0], TDI};
            tck_prev <= tck_sync[1];
        end
    end

    // Memory pin states cross from the memory clocks; a sample taken
    // while a pin moves may catch either level, which capture tolerates
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else if (CE) begin
            pin_meta <= PIN_STATE;
            pin_sync <= pin_meta;
        end
    end

    // Edge detect on the second synchroniser stage
    assign rise = tck_sync[1] & ~tck_prev;
    assign fall = ~tck_sync[1] & tck_prev;

    // ------------------------------------------------------------
    // Controller, stepped on rising test clock edges
    // ------------------------------------------------------------
    tap_fsm u_fsm (
        .clk   (SYS_CLK),
        .nrst  (NRST),
        .ce    (CE),
        .step  (rise),
        .tms   (tms_sync[1]),
        .state (state)
    );

    // ------------------------------------------------------------
    // Instruction path
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ir_shift <= IR_RESET;
            ir       <= IR_RESET;
        end else if (CE && state == ST_RESET) begin
            ir <= IR_RESET;
        end else if (CE && rise) begin
            case (state)
                ST_CAP_IR: begin
                    ir_shift <= IR_CAPTURE;
                end
                ST_SHIFT_IR: begin
                    ir_shift <= {tdi_sync[1], ir_shift[2:1]};
                end
                ST_UPD_IR: begin
                    ir <= ir_shift;
                end
                default: begin
                    ir <= ir;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data path registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            bypass   <= 1'b0;
            id_shift <= 32'h0000_0000;
            bs_shift <= '0;
        end else if (CE && rise) begin
            case (state)
                ST_CAP_DR: begin
                    bypass   <= 1'b0;
                    id_shift <= ID_CODE;
                    bs_shift <= pin_sync;
                end
                ST_SHIFT_DR: begin
                    if (ir == INS_IDENT) begin
                        id_shift <= {tdi_sync[1], id_shift[31:1]};
                    end else if (sel_boundary(ir)) begin
                        bs_shift <= {tdi_sync[1], bs_shift[BS_LEN-1:1]};
                    end else begin
                        bypass <= tdi_sync[1];
                    end
                end
                default: begin
                    bypass <= bypass;
                end
            endcase
        end
    end

    // Boundary update latch, loaded on data update
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            bs_update <= '0;
        end else if (CE && rise && state == ST_UPD_DR && sel_boundary(ir)) begin
            bs_update <= bs_shift;
        end
    end

    // ------------------------------------------------------------
    // Serial output, changes on falling test clock edges
    // ------------------------------------------------------------
    always_comb begin
        shifting = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
        if (state == ST_SHIFT_IR) begin
            next_tdo = ir_shift[0];
        end else if (ir == INS_IDENT) begin
            next_tdo = id_shift[0];
        end else if (sel_boundary(ir)) begin
            next_tdo = bs_shift[0];
        end else begin
            next_tdo = bypass;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            TDO      <= 1'b0;
            TDO_OE_N <= 1'b1;
        end else if (CE && fall) begin
            TDO      <= next_tdo;
            TDO_OE_N <= ~shifting;
        end
    end

    // ------------------------------------------------------------
    // Memory pin control from the active instruction
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            PIN_DRIVE <= '0;
            DRIVE_EN  <= 1'b0;
            FLOAT_OUT <= 1'b0;
            TAP_STATE <= 4'h0;
        end else if (CE) begin
            PIN_DRIVE <= bs_update;
            DRIVE_EN  <= (ir == INS_EXTERNAL);
            FLOAT_OUT <= (ir == INS_FLOAT);
            TAP_STATE <= state;
        end
    end

endmodule
`default_nettype wire

// [bench/tap_checker.sv]
/* Checker for the test port pins and controller state.
   Bound to sram_tap; the test clock pin is sampled by SYS_CLK. */
`timescale 1ns/1ps
`default_nettype none
module tap_checker
    import tap_pkg::*;
#(parameter int BS_LEN = 8)
(
    // Clock and reset
    input wire logic              SYS_CLK,
    input wire logic              NRST,
    // Pins and state
    input wire logic              TCK,
    input wire logic              TMS,
    input wire logic              TDO,
    input wire logic              TDO_OE_N,
    input wire logic [BS_LEN-1:0] PIN_DRIVE,
    input wire logic              DRIVE_EN,
    input wire logic              FLOAT_OUT,
    input wire logic [3:0]        TAP_STATE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    logic [2:0] ones;
    // Rises in a row with mode select high
    always_ff @(posedge SYS_CLK) begin
        if (!NRST)
            ones <= 3'h0;
        else if ($rose(TCK))
            ones <= !TMS ? 3'h0 : ones + {2'h0, ones != 3'h7};
    end
    // ----------
    // Assertions
    // ----------
    AST_RST: assert property ($rose(NRST) |-> TAP_STATE == ST_RESET && TDO_OE_N)
        else $error("not reset");
    AST_TDO_FALL: assert property ($changed(TDO) |-> !TCK && !$past(TCK, 2))
        else $error("data out moved off low phase");
    AST_STATE_RISE: assert property ($changed(TAP_STATE) |-> $past(TCK, 2))
        else $error("state moved without rise");
    AST_FIVE: assert property ($rose(TCK) && TMS && ones >= 3'h4 |-> ##[1:8] TAP_STATE == ST_RESET)
        else $error("five ones no reset");
    AST_OE: assert property (!TDO_OE_N |-> TAP_STATE inside {ST_SHIFT_DR, ST_EXIT1_DR, ST_SHIFT_IR, ST_EXIT1_IR})
        else $error("data out enabled off shift");
    AST_INERT: assert property (!TCK [*8] |-> $stable(TAP_STATE) && $stable(TDO))
        else $error("moved with clock low");
    AST_DEFAULT: assert property (TAP_STATE == ST_RESET |-> ##[0:4] !DRIVE_EN && !FLOAT_OUT)
        else $error("test mode after reset");
    AST_HOLD: assert property (TAP_STATE == ST_SHIFT_DR && $past(TAP_STATE) == ST_SHIFT_DR |-> $stable(PIN_DRIVE))
        else $error("drive latch moved in shift");
    CV_IR: cover property (TAP_STATE == ST_SHIFT_IR);
    CV_DRV: cover property ($rose(DRIVE_EN));
    CV_FLT: cover property ($rose(FLOAT_OUT));
endmodule
bind sram_tap tap_checker #(.BS_LEN(BS_LEN)) chk (.SYS_CLK, .NRST, .TCK, .TMS, .TDO, .TDO_OE_N,
    .PIN_DRIVE, .DRIVE_EN, .FLOAT_OUT, .TAP_STATE);
`default_nettype wire

// [bench/tap_host.sv]
/* Model of the outside scan controller.
   Drives pins from SYS_CLK edges; only reads data out. */
`timescale 1ns/1ps
`default_nettype none
module tap_host (
    // Clock
    input wire logic SYS_CLK,
    // Test port pins
    output var logic TCK,
    output var logic TMS,
    output var logic TDI,
    input wire logic TDO
);
    // Parked pins: clock low, data lines at pull-up level
    initial begin
        TCK = 1'h0;
        TMS = 1'h1;
        TDI = 1'h1;
    end
    // One test clock of eight SYS_CLK; data out read before the rise
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge SYS_CLK);
        TMS <= m;
        TDI <= d;
        repeat (3) @(posedge SYS_CLK);
        q = TDO;
        TCK <= 1'h1;
        repeat (4) @(posedge SYS_CLK);
        TCK <= 1'h0;
        TMS <= 1'h1;
        TDI <= 1'h1;
    endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
/* Self-checking bench for sram_tap through the host model.
   Assumes tap_host and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e,m) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %0t %s", $time, m); end end
module testbench;
    import tap_pkg::*;
    localparam logic [31:0] ID = 32'h5EED_0F01; // Arbitrary value
    logic        SYS_CLK = 1'h0;
    logic        NRST = 1'h0;
    logic        CE = 1'h1;
    logic [7:0]  PIN_STATE = 8'h0;
    logic        TCK, TMS, TDI, TDO, TDO_OE_N, DRIVE_EN, FLOAT_OUT;
    logic [7:0]  PIN_DRIVE;
    logic [3:0]  TAP_STATE;
    logic [63:0] d;
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;
    sram_tap #(.BS_LEN(8), .ID_CODE(ID)) dut (.SYS_CLK, .NRST, .CE, .TCK, .TMS, .TDI, .TDO, .TDO_OE_N,
        .PIN_STATE, .PIN_DRIVE, .DRIVE_EN, .FLOAT_OUT, .TAP_STATE);
    tap_host host (.SYS_CLK, .TCK, .TMS, .TDI, .TDO);
    // Clock and hang guard
    always #50 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (3) @(posedge SYS_CLK);
    endtask
    // -------------------------------------------------
    // Idle, capture, shift n bits lsb first, update, idle
    // -------------------------------------------------
    task automatic scan(input logic ir, input int n, input logic [63:0] din);
        logic q;
        d = 64'h0;
        host.step(1'h1, 1'h1, q);
        if (ir)
            host.step(1'h1, 1'h1, q);
        repeat (2) host.step(1'h0, 1'h1, q);
        for (int i = 0; i < n; i++) begin
            host.step(i == n - 1, din[i], q);
            d[i] = q;
            if (i == 0) `CHK(TDO_OE_N, 1'h0, "data out enable");
        end
        host.step(1'h1, 1'h1, q);
        host.step(1'h0, 1'h1, q);
        settle();
    endtask
    task automatic t_reset();
        `CHK(TAP_STATE, ST_RESET, "reset state");
        `CHK(TDO_OE_N, 1'h1, "data out enabled");
        host.step(1'h0, 1'h1, d[0]);
        scan(1'h0, 32, 64'h0);
        `CHK(d[31:0], ID, "identity");
    endtask
    task automatic t_bypass();
        scan(1'h1, 3, 64'(INS_BYPASS));
        `CHK(d[2:0], IR_CAPTURE, "ir capture");
        scan(1'h0, 8, 64'hB4);
        `CHK(d[7:0], 8'h68, "bypass path");
    endtask
    task automatic t_float();
        PIN_STATE <= 8'h5A;
        scan(1'h1, 3, 64'(INS_FLOAT));
        `CHK({FLOAT_OUT, DRIVE_EN}, 2'h2, "float mode");
        scan(1'h0, 8, 64'h3C);
        `CHK(d[7:0], 8'h5A, "pin capture");
        `CHK(PIN_DRIVE, 8'h3C, "update latch");
    endtask
    task automatic t_extest();
        PIN_STATE <= 8'hC3;
        scan(1'h1, 3, 64'(INS_SAMPLE));
        `CHK(FLOAT_OUT, 1'h0, "sample floats");
        scan(1'h0, 8, 64'h96);
        `CHK(d[7:0], 8'hC3, "sample capture");
        scan(1'h1, 3, 64'(INS_EXTERNAL));
        `CHK({DRIVE_EN, PIN_DRIVE}, 9'h196, "preload drive");
    endtask
    // Ones from inside a data shift: four must not reset, five must
    task automatic t_tlr();
        logic q;
        host.step(1'h1, 1'h1, q);
        repeat (2) host.step(1'h0, 1'h1, q);
        repeat (4) host.step(1'h1, 1'h1, q);
        settle();
        `CHK(TAP_STATE, ST_SEL_IR, "four ones");
        host.step(1'h1, 1'h1, q);
        settle();
        `CHK({TAP_STATE, DRIVE_EN}, 5'h0, "five ones");
        host.step(1'h0, 1'h1, q);
        scan(1'h0, 32, 64'h0);
        `CHK(d[31:0], ID, "identity again");
        repeat (20) @(posedge SYS_CLK);
        `CHK(TAP_STATE, ST_IDLE, "clock held low");
    endtask
    // Enable low: a whole test clock passes unseen
    task automatic t_freeze();
        logic q;
        CE <= 1'h0;
        host.step(1'h1, 1'h1, q);
        CE <= 1'h1;
        settle();
        `CHK(TAP_STATE, ST_IDLE, "enable low");
    endtask
    initial begin
        repeat (10) @(posedge SYS_CLK);
        NRST <= 1'h1;
        repeat (4) @(posedge SYS_CLK);
        t_reset();
        t_bypass();
        t_float();
        t_extest();
        t_tlr();
        t_freeze();
        report_and_stop();
    end
endmodule
`default_nettype wire
